// File: bench/dcu_bus_target.sv
// Memory and peripheral target answering each bus piece
`default_nettype none
module dcu_bus_target (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Answer speed
  input wire logic slow_in,
  // Bus handshake
  input wire logic bus_req_in,
  output logic bus_ack_out,
  // Completed pieces
  output logic [7:0] pieces_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  // One ack per piece; slow mode makes the engine hold its request longer
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_q <= 2'h0;
      bus_ack_out <= 1'b0;
      pieces_out <= 8'h0;
    end else begin
      bus_ack_out <= 1'b0;
      if (bus_req_in && !bus_ack_out) begin
        if (wait_q == (slow_in ? 2'h3 : 2'h0)) begin
          bus_ack_out <= 1'b1;
          wait_q <= 2'h0;
          pieces_out <= pieces_out + 8'h1;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end else begin
        wait_q <= 2'h0;
      end
    end
  end
endmodule // dcu_bus_target
`default_nettype wire

// File: bench/dcu_channel_props.sv
// Port-level assertions for the DMA channel update block
`default_nettype none
module dcu_props (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // System events
  input wire logic addr_err_in,
  input wire logic nmi_in,
  input wire logic standby_in,
  // System bus
  input wire logic bus_req_out,
  input wire logic bus_wr_out,
  input wire logic [31:0] bus_addr_out,
  input wire logic [1:0] bus_size_out,
  input wire logic bus_ack_in,
  // Interrupts and status
  input wire logic esc_irq_out,
  input wire logic cend_irq_out,
  input wire logic active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_piece_hold;
    bus_req_out && !bus_ack_in && !(addr_err_in || nmi_in || standby_in) |=>
      bus_req_out && $stable(bus_addr_out) && $stable(bus_size_out) && $stable(bus_wr_out);
  endproperty
  a_piece_hold: assert property (p_piece_hold) else $error("bus piece changed early");
  property p_fault_drop;
    addr_err_in || nmi_in |=> !bus_req_out;
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("bus kept after fault");
  property p_standby_drop;
    standby_in |=> !bus_req_out;
  endproperty
  a_standby_drop: assert property (p_standby_drop) else $error("bus kept in standby");
  property p_size_code;
    bus_req_out |-> bus_size_out != 2'h3;
  endproperty
  a_size_code: assert property (p_size_code) else $error("illegal piece size");
  // pieces sit on their own boundary
  property p_piece_align;
    bus_req_out |-> (bus_addr_out & ((32'h1 << bus_size_out) - 32'h1)) == 32'h0;
  endproperty
  a_piece_align: assert property (p_piece_align) else $error("misaligned piece");
  // read pieces climb by the size just done
  property p_read_climb;
    bus_req_out && bus_ack_in && !bus_wr_out ##1 bus_req_out && !bus_wr_out |->
      bus_addr_out == $past(bus_addr_out) + (32'h1 << $past(bus_size_out));
  endproperty
  a_read_climb: assert property (p_read_climb) else $error("read piece skipped bytes");
  // write pieces climb the same way
  property p_write_climb;
    bus_req_out && bus_ack_in && bus_wr_out ##1 bus_req_out && bus_wr_out |->
      bus_addr_out == $past(bus_addr_out) + (32'h1 << $past(bus_size_out));
  endproperty
  a_write_climb: assert property (p_write_climb) else $error("write piece skipped bytes");
  // a channel that has just gone idle owns no bus cycle
  property p_idle_quiet;
    $fell(active_out) |-> !bus_req_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("bus busy while idle");
  property p_esc_stopped;
    $rose(esc_irq_out) |-> !active_out;
  endproperty
  a_esc_stopped: assert property (p_esc_stopped) else $error("escape while active");
  property p_cend_stopped;
    $rose(cend_irq_out) |-> !active_out;
  endproperty
  a_cend_stopped: assert property (p_cend_stopped) else $error("count end while active");
  // read data stands one cycle only
  property p_rdata_once;
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rdata_once: assert property (p_rdata_once) else $error("read data outside slot");
endmodule // dcu_props
bind dcu_channel dcu_props u_dcu_props (.core_clk_in, .nrst_in, .reg_rd_in, .reg_rdata_out,
  .addr_err_in, .nmi_in, .standby_in, .bus_req_out, .bus_wr_out, .bus_addr_out,
  .bus_size_out, .bus_ack_in, .esc_irq_out, .cend_irq_out, .active_out);
`default_nettype wire

// File: bench/test_dma_channel_register_update.sv
// Register-level testbench for the DMA channel update block
`default_nettype none
module test_dma_channel_register_update;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] all_ones = 32'hffffffff;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic dreq_n_in = 1'b1;
  logic addr_err_in = 1'b0;
  logic nmi_in = 1'b0;
  logic standby_in = 1'b0;
  logic slow = 1'b0;
  wire logic [31:0] reg_rdata_out;
  wire logic bus_req_out, bus_wr_out, bus_ack_in, esc_irq_out, cend_irq_out, active_out;
  wire logic [31:0] bus_addr_out;
  wire logic [1:0] bus_size_out;
  wire logic [7:0] pieces;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] v, st;
  logic [7:0] p0;
  // Block under test and its bus partner
  dcu_channel u_dcu_channel (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .dreq_n_in, .addr_err_in, .nmi_in, .standby_in, .bus_req_out,
    .bus_wr_out, .bus_addr_out, .bus_size_out, .bus_ack_in, .esc_irq_out, .cend_irq_out,
    .active_out);
  dcu_bus_target u_dcu_bus_target (.clk_in(core_clk_in), .nrst_in, .slow_in(slow),
    .bus_req_in(bus_req_out), .bus_ack_out(bus_ack_in), .pieces_out(pieces));
  // 250 MHz clock
  initial forever #2 core_clk_in = ~core_clk_in;
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(n, d & m, e);
  endtask
  // Stop first and confirm, since live registers must not be written
  task automatic cfg(input logic [31:0] s, d, c, b, a, o, m);
    wr(8'h10, 32'h0);
    rc("stopped", 8'h10, 32'h1, 32'h0);
    wr(8'h00, s);
    wr(8'h04, d);
    wr(8'h08, c);
    wr(8'h0c, b);
    wr(8'h14, a);
    wr(8'h18, o);
    wr(8'h10, m);
  endtask
  task automatic pulse();
    @(posedge core_clk_in);
    dreq_n_in <= 1'b0;
    @(posedge core_clk_in);
    dreq_n_in <= 1'b1;
  endtask
  // One request; bounded wait for the channel to go active and idle again
  task automatic go(input bit busy, input logic [31:0] stop);
    int i;
    bit up;
    up = 1'b0;
    pulse();
    repeat (busy ? 0 : 10) @(posedge core_clk_in);
    for (i = 0; busy && i < 500 && !(up && active_out === 1'b0); i++) begin
      @(posedge core_clk_in);
      // Look after the edge so the flag has settled
      #1;
      if (active_out === 1'b1) begin
        if (stop != 32'h0 && !up) wr(8'h10, stop);
        up = 1'b1;
      end
    end
    if (i == 500) begin
      error_cnt++;
      $display("CHECK FAILED transfer wait expected idle seen timeout");
      print_verdict();
    end
  endtask
  function automatic logic [31:0] upd(input logic [31:0] a, input logic [1:0] sel,
      input logic [31:0] s, o);
    case (sel)
      2'h0: return a;
      2'h1: return a + o;
      2'h2: return a + s;
      default: return a - s;
    endcase
  endfunction
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rc("mode reset", 8'h10, all_ones, 32'h0);
    rc("unmapped", 8'h1c, all_ones, 32'h0);
    // Every selector with every size, negative offset
    for (int s = 0; s < 4; s++) begin
      for (int z = 0; z < 3; z++) begin
        st = 32'h1 << z;
        slow <= s[0];
        cfg(32'h1000, 32'h2000, 32'h8, 32'h0, {28'h0, 2'(3 - s), 2'(s)}, 32'hfffffff0,
          {22'h0, 2'(z), 8'h1});
        go(1'b1, 1'b0);
        rc("src", 8'h00, all_ones, upd(32'h1000, 2'(s), st, 32'hfffffff0));
        rc("dst", 8'h04, all_ones, upd(32'h2000, 2'(3 - s), st, 32'hfffffff0));
        rc("count", 8'h08, all_ones, 32'h8 - st);
      end
    end
    // Unaligned longword on both sides
    slow <= 1'b1;
    cfg(32'h1001, 32'h2003, 32'h10, 32'h0, 32'he, 32'h0, 32'h201);
    p0 = pieces;
    go(1'b1, 1'b0);
    rc("split src", 8'h00, all_ones, 32'h1005);
    rc("split dst", 8'h04, all_ones, 32'h1fff);
    check("pieces", {24'h0, pieces - p0}, 32'h6);
    slow <= 1'b0;
    // Last unit ends the count
    cfg(32'h1000, 32'h2000, 32'h2, 32'h0, 32'ha, 32'h0, 32'h151);
    go(1'b1, 1'b0);
    rc("count end", 8'h08, all_ones, 32'h0);
    rc("count end flags", 8'h10, 32'h21, 32'h20);
    check("count end irq", {31'h0, cend_irq_out}, 32'h1);
    // Zero count moves data but never counts
    cfg(32'h1000, 32'h2000, 32'h0, 32'h0, 32'ha, 32'h0, 32'h101);
    go(1'b1, 1'b0);
    rc("zero count", 8'h08, all_ones, 32'h0);
    rc("zero count src", 8'h00, all_ones, 32'h1002);
    // Repeat area on each side, then resume
    for (int side = 0; side < 2; side++) begin
      cfg(32'h1000, 32'h2000, 32'h40, 32'h00020002, {24'h0, 1'b1, 2'h0, 1'(side), 4'ha},
        32'h0, 32'h411);
      go(1'b1, 1'b0);
      rc("block count", 8'h0c, all_ones, 32'h00020001);
      go(1'b1, 1'b0);
      rc("block reload", 8'h0c, all_ones, 32'h00020002);
      rc("repeat src", 8'h00, all_ones, side == 0 ? 32'h1000 : 32'h1002);
      rc("repeat dst", 8'h04, all_ones, side == 1 ? 32'h2000 : 32'h2002);
      rc("repeat end", 8'h10, 32'h9, 32'h8);
      check("escape irq", {31'h0, esc_irq_out}, 32'h1);
      wr(8'h10, 32'h411);
      repeat (2) @(posedge core_clk_in);
      check("resume irq", {31'h0, esc_irq_out}, 32'h0);
      rc("resume flag", 8'h10, 32'h8, 32'h0);
    end
    // Extended area wraps the low bits only
    cfg(32'h100e, 32'h2000, 32'h40, 32'h0, 32'h42a, 32'h0, 32'h111);
    go(1'b1, 1'b0);
    rc("area src", 8'h00, all_ones, 32'h1000);
    rc("area stop", 8'h10, 32'h9, 32'h8);
    // Count below one unit is refused
    cfg(32'h1000, 32'h2000, 32'h1, 32'h0, 32'ha, 32'h0, 32'h211);
    go(1'b0, 1'b0);
    rc("size error", 8'h10, 32'h9, 32'h8);
    rc("size error src", 8'h00, all_ones, 32'h1000);
    // Stop write during a burst lets only a short tail through
    cfg(32'h1000, 32'h2000, 32'h40, 32'h0, 32'ha, 32'h0, 32'h1001);
    go(1'b1, 32'h1000);
    rd(8'h08, v);
    check("burst tail", {31'h0, v >= 32'h3c && v < 32'h40}, 32'h1);
    rc("burst stop", 8'h10, 32'h3, 32'h0);
    // Stop write inside a block lets the whole block finish
    cfg(32'h1000, 32'h2000, 32'h40, 32'h00040004, 32'ha, 32'h0, 32'h801);
    go(1'b1, 32'h800);
    rc("block finish", 8'h08, all_ones, 32'h3c);
    rc("block src", 8'h00, all_ones, 32'h1000);
    rc("block dst", 8'h04, all_ones, 32'h2004);
    rc("block size", 8'h0c, all_ones, 32'h00040004);
    rc("block stop", 8'h10, 32'h3, 32'h0);
    // Standby, address error and NMI during a burst
    for (int e = 0; e < 3; e++) begin
      cfg(32'h1000, 32'h2000, 32'h40, 32'h0, 32'ha, 32'h0, 32'h1001);
      pulse();
      repeat (8) @(posedge core_clk_in);
      {nmi_in, addr_err_in, standby_in} <= 3'h1 << e;
      @(posedge core_clk_in);
      {nmi_in, addr_err_in, standby_in} <= 3'h0;
      repeat (4) @(posedge core_clk_in);
      rc("fault stop", 8'h10, 32'h5, e == 0 ? 32'h0 : 32'h4);
    end
    print_verdict();
  end
endmodule // test_dma_channel_register_update
`default_nettype wire

// File: hdl/dcu_channel.v
// Single DMA channel: address, count, block counter and status flag update
`default_nettype none
`include "dcu_regs.vh"

module dcu_channel (
  // Clock and reset
  input wire core_clk_in,
  input wire nrst_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Request pin and system events
  input wire dreq_n_in,
  input wire addr_err_in,
  input wire nmi_in,
  input wire standby_in,
  // System bus toward memory and peripherals
  output reg bus_req_out,
  output reg bus_wr_out,
  output reg [31:0] bus_addr_out,
  output reg [1:0] bus_size_out,
  input wire bus_ack_in,
  // Interrupt requests
  output reg esc_irq_out,
  output reg cend_irq_out,
  // Status
  output reg active_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RD = 2'h1;
  localparam ST_WR = 2'h2;

  // Next address per selector; offset is a plain modulo add
  function [31:0] addr_step;
    input [31:0] a;
    input [1:0] sel;
    input [31:0] step;
    input [31:0] ofs;
    begin
      case (sel)
        `DCU_UPD_FIX: addr_step = a;
        `DCU_UPD_OFS: addr_step = a + ofs;
        `DCU_UPD_INC: addr_step = a + step;
        `DCU_UPD_DEC: addr_step = a - step;
        default: addr_step = a;
      endcase
    end
  endfunction

  // Low bit mask of an extended area; zero width means no area
  function [31:0] area_mask;
    input [4:0] n;
    begin
      if (n == 5'h00) begin
        area_mask = 32'hffffffff;
      end else begin
        area_mask = ~(32'hffffffff << n);
      end
    end
  endfunction

  // Largest aligned piece that fits the bytes still to move
  function [2:0] piece_bytes;
    input [1:0] a;
    input [2:0] rem;
    begin
      if (a[0] || rem == 3'h1) begin
        piece_bytes = 3'h1;
      end else if (a[1] || rem < 3'h4) begin
        piece_bytes = 3'h2;
      end else begin
        piece_bytes = 3'h4;
      end
    end
  endfunction

  function [1:0] size_code;
    input [2:0] b;
    begin
      case (b)
        3'h1: size_code = `DCU_SZ_BYTE;
        3'h2: size_code = `DCU_SZ_WORD;
        default: size_code = `DCU_SZ_LONG;
      endcase
    end
  endfunction

  // Software visible state
  reg [31:0] src_q;
  reg [31:0] dst_q;
  reg [31:0] cnt_q;
  reg [31:0] bsz_q;
  reg [31:0] ofs_q;
  reg [31:0] actl_q;
  reg run_q;
  reg fault_q;
  reg esc_q;
  reg escie_q;
  reg cend_q;
  reg cendie_q;
  reg [1:0] dsz_q;
  reg [1:0] tmode_q;
  reg burst_q;
  // Engine state
  reg [1:0] st_q;
  reg [31:0] start_src_q;
  reg [31:0] start_dst_q;
  reg [31:0] pa_q;
  reg [2:0] rem_q;
  reg [1:0] tail_q;
  reg req_pend_q;
  reg dreq_s1_q;
  reg dreq_s2_q;

  // Decoded fields
  wire [1:0] src_sel = actl_q[`DCU_A_SRC_HI:`DCU_A_SRC_LO];
  wire [1:0] dst_sel = actl_q[`DCU_A_DST_HI:`DCU_A_DST_LO];
  wire [4:0] src_area = actl_q[`DCU_A_SAREA_HI:`DCU_A_SAREA_LO];
  wire [4:0] dst_area = actl_q[`DCU_A_DAREA_HI:`DCU_A_DAREA_LO];
  wire rside = actl_q[`DCU_A_RSIDE];
  wire blk_mode = (tmode_q == `DCU_TM_BLOCK);
  wire rpt_mode = (tmode_q == `DCU_TM_REPEAT);
  wire wr_mode = reg_wr_in && (reg_addr_in == `DCU_OFS_MODE);
  wire sw_stop = wr_mode && !reg_wdata_in[`DCU_M_RUN];
  wire sw_resume = wr_mode && reg_wdata_in[`DCU_M_RUN] && !run_q;
  wire fault = addr_err_in || nmi_in;

  // Combinational transfer results
  reg [31:0] step;
  reg [2:0] step_b;
  reg [2:0] pb;
  reg [31:0] s_raw;
  reg [31:0] d_raw;
  reg [31:0] s_mask;
  reg [31:0] d_mask;
  reg [31:0] src_new;
  reg [31:0] dst_new;
  reg [31:0] cnt_new;
  reg [15:0] bcnt_new;
  reg s_ovf;
  reg d_ovf;
  reg blk_end;
  reg xfer_end;
  reg tot_done;
  reg size_err;
  reg start;
  reg esc_evt;
  reg stop_evt;
  reg cont;

  always @* begin
    case (dsz_q)
      `DCU_SZ_BYTE: step_b = 3'h1;
      `DCU_SZ_WORD: step_b = 3'h2;
      default: step_b = 3'h4;
    endcase
    step = {29'h0, step_b};
    pb = piece_bytes(pa_q[1:0], rem_q);
    xfer_end = (st_q == ST_WR) && bus_ack_in && (rem_q == pb);
    // block counter reloads instead of zero
    blk_end = (blk_mode || rpt_mode) && (bsz_q[`DCU_BSZ_LO] == 16'h0001);
    bcnt_new = blk_end ? bsz_q[`DCU_BSZ_HI] : (bsz_q[`DCU_BSZ_LO] - 16'h0001);
    // source update; from read start; modulo offset
    s_raw = addr_step(src_q, src_sel, step, ofs_q);
    d_raw = addr_step(dst_q, dst_sel, step, ofs_q);
    s_mask = area_mask(src_area);
    d_mask = area_mask(dst_area);
    s_ovf = (src_area != 5'h00) && (((src_q ^ s_raw) & ~s_mask) != 32'h0);
    d_ovf = (dst_area != 5'h00) && (((dst_q ^ d_raw) & ~d_mask) != 32'h0);
    src_new = (src_q & ~s_mask) | (s_raw & s_mask);
    dst_new = (dst_q & ~d_mask) | (d_raw & d_mask);
    // source side reload at block end
    if (blk_end && !rside) begin
      src_new = start_src_q;
      s_ovf = 1'b0;
    end
    // destination side reload at block end
    if (blk_end && rside) begin
      dst_new = start_dst_q;
      d_ovf = 1'b0;
    end
    // count drops by bytes; zero never counts
    cnt_new = (cnt_q == 32'h0) ? cnt_q : (cnt_q - step);
    tot_done = xfer_end && (cnt_q != 32'h0) && (cnt_new == 32'h0);
    start = (st_q == ST_IDLE) && run_q && req_pend_q && !fault;
    // Count left smaller than one unit cannot be moved
    size_err = start && (cnt_q != 32'h0) && (cnt_q < step);
    esc_evt = size_err || (xfer_end && ((rpt_mode && blk_end && actl_q[`DCU_A_RPTIE])
      || (s_ovf && actl_q[`DCU_A_SOVIE]) || (d_ovf && actl_q[`DCU_A_DOVIE])));
    stop_evt = tot_done || esc_evt;
    // block runs to its end; burst tail after stop
    cont = xfer_end && !stop_evt && !fault
      && ((blk_mode && !blk_end)
      || (!blk_mode && burst_q && ((run_q && !sw_stop) || tail_q != 2'h0)));
  end

  // Pin request passes two flops before use
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dreq_s1_q <= 1'b1;
      dreq_s2_q <= 1'b1;
    end else begin
      dreq_s1_q <= dreq_n_in;
      dreq_s2_q <= dreq_s1_q;
    end
  end

  // Transfer sequencer and bus cycle control
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      pa_q <= 32'h0;
      rem_q <= 3'h0;
      tail_q <= 2'h0;
      bus_req_out <= 1'b0;
      bus_wr_out <= 1'b0;
      bus_addr_out <= 32'h0;
      bus_size_out <= `DCU_SZ_BYTE;
      active_out <= 1'b0;
    end else begin
      // arm burst tail on stop write
      if (sw_stop && run_q && burst_q && st_q != ST_IDLE) begin
        tail_q <= `DCU_BURST_TAIL;
      end else if (xfer_end && !run_q && tail_q != 2'h0) begin
        tail_q <= tail_q - 2'h1;
      end else if (st_q == ST_IDLE) begin
        tail_q <= 2'h0;
      end
      // fault abandons the transfer at once
      if (fault || standby_in) begin
        st_q <= ST_IDLE;
        bus_req_out <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (start && !size_err) begin
              st_q <= ST_RD;
              pa_q <= src_q;
              rem_q <= step_b;
              bus_req_out <= 1'b1;
              bus_wr_out <= 1'b0;
              bus_addr_out <= src_q;
              bus_size_out <= size_code(piece_bytes(src_q[1:0], step_b));
            end
          end
          ST_RD: begin
            // read pieces walk up from start
            if (bus_ack_in) begin
              if (rem_q == pb) begin
                st_q <= ST_WR;
                pa_q <= dst_q;
                rem_q <= step_b;
                bus_wr_out <= 1'b1;
                bus_addr_out <= dst_q;
                bus_size_out <= size_code(piece_bytes(dst_q[1:0], step_b));
              end else begin
                pa_q <= pa_q + {29'h0, pb};
                rem_q <= rem_q - pb;
                bus_addr_out <= pa_q + {29'h0, pb};
                bus_size_out <= size_code(piece_bytes(pa_q[1:0] + pb[1:0], rem_q - pb));
              end
            end
          end
          ST_WR: begin
            // write pieces walk up from start
            if (bus_ack_in) begin
              if (xfer_end) begin
                if (cont) begin
                  st_q <= ST_RD;
                  pa_q <= src_new;
                  rem_q <= step_b;
                  bus_wr_out <= 1'b0;
                  bus_addr_out <= src_new;
                  bus_size_out <= size_code(piece_bytes(src_new[1:0], step_b));
                end else begin
                  st_q <= ST_IDLE;
                  bus_req_out <= 1'b0;
                  bus_wr_out <= 1'b0;
                end
              end else begin
                pa_q <= pa_q + {29'h0, pb};
                rem_q <= rem_q - pb;
                bus_addr_out <= pa_q + {29'h0, pb};
                bus_size_out <= size_code(piece_bytes(pa_q[1:0] + pb[1:0], rem_q - pb));
              end
            end
          end
          default: begin
            st_q <= ST_IDLE;
            bus_req_out <= 1'b0;
          end
        endcase
      end
      // active unless idle or waiting for request
      active_out <= (st_q != ST_IDLE) && !fault && !standby_in
        && !(xfer_end && !cont) && !(st_q == ST_IDLE);
    end
  end

  // Registers: CPU writes over transfer updates; stop causes and flag sets win over CPU writes
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_q <= 32'h0;
      dst_q <= 32'h0;
      cnt_q <= 32'h0;
      bsz_q <= 32'h0;
      ofs_q <= 32'h0;
      actl_q <= 32'h0;
      start_src_q <= 32'h0;
      start_dst_q <= 32'h0;
      run_q <= 1'b0;
      fault_q <= 1'b0;
      esc_q <= 1'b0;
      escie_q <= 1'b0;
      cend_q <= 1'b0;
      cendie_q <= 1'b0;
      dsz_q <= `DCU_SZ_BYTE;
      tmode_q <= `DCU_TM_NORMAL;
      burst_q <= 1'b0;
      req_pend_q <= 1'b0;
    end else begin
      // CPU address write wins over update
      if (reg_wr_in && reg_addr_in == `DCU_OFS_SRC) begin
        src_q <= reg_wdata_in;
      end else if (xfer_end) begin
        src_q <= src_new;
      end
      if (reg_wr_in && reg_addr_in == `DCU_OFS_DST) begin
        dst_q <= reg_wdata_in;
      end else if (xfer_end) begin
        dst_q <= dst_new;
      end
      // CPU count stored, stop still follows
      if (reg_wr_in && reg_addr_in == `DCU_OFS_CNT) begin
        cnt_q <= reg_wdata_in;
      end else if (xfer_end) begin
        cnt_q <= cnt_new;
      end
      if (reg_wr_in && reg_addr_in == `DCU_OFS_BSZ) begin
        bsz_q <= reg_wdata_in;
      end else if (xfer_end && (blk_mode || rpt_mode)) begin
        bsz_q[`DCU_BSZ_LO] <= bcnt_new;
      end
      if (reg_wr_in && reg_addr_in == `DCU_OFS_AOFS) begin
        ofs_q <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == `DCU_OFS_ACTL) begin
        actl_q <= reg_wdata_in;
      end
      // Mode fields; flags clear by writing zero
      if (wr_mode) begin
        escie_q <= reg_wdata_in[`DCU_M_ESCIE];
        cendie_q <= reg_wdata_in[`DCU_M_CENDIE];
        dsz_q <= reg_wdata_in[`DCU_M_SZ_HI:`DCU_M_SZ_LO];
        tmode_q <= reg_wdata_in[`DCU_M_TM_HI:`DCU_M_TM_LO];
        burst_q <= reg_wdata_in[`DCU_M_BURST];
      end
      // Start addresses taken on each resume for reloads
      if (sw_resume) begin
        start_src_q <= src_q;
        start_dst_q <= dst_q;
      end
      // run enable self-clears on any stop cause
      if (fault || standby_in || stop_evt) begin
        run_q <= 1'b0;
      end else if (wr_mode) begin
        run_q <= reg_wdata_in[`DCU_M_RUN];
      end
      // fault flag set with or without a transfer
      if (fault) begin
        fault_q <= 1'b1;
      end else if (wr_mode && !reg_wdata_in[`DCU_M_FAULT]) begin
        fault_q <= 1'b0;
      end
      // escape set as active drops; set beats clear
      if (esc_evt) begin
        esc_q <= 1'b1;
      end else if (sw_resume || (wr_mode && !reg_wdata_in[`DCU_M_ESC])) begin
        esc_q <= 1'b0;
      end
      if (tot_done) begin
        cend_q <= 1'b1;
      end else if (sw_resume || (wr_mode && !reg_wdata_in[`DCU_M_CEND])) begin
        cend_q <= 1'b0;
      end
      if (sw_resume || start || !run_q) begin
        req_pend_q <= 1'b0;
      end else if (!dreq_s2_q && st_q == ST_IDLE) begin
        req_pend_q <= 1'b1;
      end
    end
  end

  // Interrupt requests and read data
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      esc_irq_out <= 1'b0;
      cend_irq_out <= 1'b0;
      reg_rdata_out <= 32'h0;
    end else begin
      // escape request needs flag and enable
      esc_irq_out <= esc_q && escie_q;
      // count-end request needs flag and enable
      cend_irq_out <= cend_q && cendie_q;
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `DCU_OFS_SRC: reg_rdata_out <= src_q;
          `DCU_OFS_DST: reg_rdata_out <= dst_q;
          `DCU_OFS_CNT: reg_rdata_out <= cnt_q;
          `DCU_OFS_BSZ: reg_rdata_out <= bsz_q;
          `DCU_OFS_AOFS: reg_rdata_out <= ofs_q;
          `DCU_OFS_ACTL: reg_rdata_out <= actl_q;
          `DCU_OFS_MODE: begin
            reg_rdata_out[`DCU_M_RUN] <= run_q;
            reg_rdata_out[`DCU_M_ACT] <= active_out;
            reg_rdata_out[`DCU_M_FAULT] <= fault_q;
            reg_rdata_out[`DCU_M_ESC] <= esc_q;
            reg_rdata_out[`DCU_M_ESCIE] <= escie_q;
            reg_rdata_out[`DCU_M_CEND] <= cend_q;
            reg_rdata_out[`DCU_M_CENDIE] <= cendie_q;
            reg_rdata_out[`DCU_M_SZ_HI:`DCU_M_SZ_LO] <= dsz_q;
            reg_rdata_out[`DCU_M_TM_HI:`DCU_M_TM_LO] <= tmode_q;
            reg_rdata_out[`DCU_M_BURST] <= burst_q;
          end
          // Unmapped addresses read as zero
          default: reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

endmodule // dcu_channel
`default_nettype wire

// File: hdl/dcu_regs.vh
// Register map, field positions and codes for the DMA channel update block
`ifndef DCU_REGS_VH
`define DCU_REGS_VH
// Word offsets of the register file
`define DCU_OFS_SRC 8'h00
`define DCU_OFS_DST 8'h04
`define DCU_OFS_CNT 8'h08
`define DCU_OFS_BSZ 8'h0c
`define DCU_OFS_MODE 8'h10
`define DCU_OFS_ACTL 8'h14
`define DCU_OFS_AOFS 8'h18
// Channel mode register fields
`define DCU_M_RUN 0
`define DCU_M_ACT 1
`define DCU_M_FAULT 2
`define DCU_M_ESC 3
`define DCU_M_ESCIE 4
`define DCU_M_CEND 5
`define DCU_M_CENDIE 6
`define DCU_M_SZ_LO 8
`define DCU_M_SZ_HI 9
`define DCU_M_TM_LO 10
`define DCU_M_TM_HI 11
`define DCU_M_BURST 12
// Address control register fields
`define DCU_A_SRC_LO 0
`define DCU_A_SRC_HI 1
`define DCU_A_DST_LO 2
`define DCU_A_DST_HI 3
`define DCU_A_RSIDE 4
`define DCU_A_SOVIE 5
`define DCU_A_DOVIE 6
`define DCU_A_RPTIE 7
`define DCU_A_SAREA_LO 8
`define DCU_A_SAREA_HI 12
`define DCU_A_DAREA_LO 16
`define DCU_A_DAREA_HI 20
// Address update selector codes
`define DCU_UPD_FIX 2'h0
`define DCU_UPD_OFS 2'h1
`define DCU_UPD_INC 2'h2
`define DCU_UPD_DEC 2'h3
// Access size codes
`define DCU_SZ_BYTE 2'h0
`define DCU_SZ_WORD 2'h1
`define DCU_SZ_LONG 2'h2
// Transfer mode codes
`define DCU_TM_NORMAL 2'h0
`define DCU_TM_REPEAT 2'h1
`define DCU_TM_BLOCK 2'h2
// Block size register halves
`define DCU_BSZ_HI 31:16
`define DCU_BSZ_LO 15:0
// Burst transfers still allowed after a stop write
`define DCU_BURST_TAIL 2'h3
`endif
